// file: rtl/ldac_params.svh
// constants for the led driver i2c address decoder
`ifndef LDAC_PARAMS_SVH
`define LDAC_PARAMS_SVH
`define LDAC_CLK_NS          25
`define LDAC_SPIKE_NS        50
`define LDAC_SPIKE_CYC       ((`LDAC_SPIKE_NS + `LDAC_CLK_NS - 1) / `LDAC_CLK_NS)
`define LDAC_TIMEOUT_MS      25
`define LDAC_TIMEOUT_CYC     ((`LDAC_TIMEOUT_MS * 1000000 + `LDAC_CLK_NS - 1) / `LDAC_CLK_NS)
`define LDAC_GROUP_DEFAULT   7'h48
`define LDAC_SUB1_DEFAULT    7'h49
`define LDAC_SUB2_DEFAULT    7'h4a
`define LDAC_SUB3_DEFAULT    7'h4c
`define LDAC_SOFT_RESET_ADDR 7'h03
`define LDAC_FIXED_UPPER     3'h4
`define LDAC_LAST_BIT        3'h7
`define LDAC_DIR_READ        1'b1
`endif

// file: rtl/ldac_pkg.sv
// types shared by the address decoder modules
package ldac_pkg;
  typedef enum {
    LDAC_IDLE,
    LDAC_ADDR,
    LDAC_ACK_WAIT,
    LDAC_ACK,
    LDAC_PASS
  } ldac_state_t;

  typedef enum logic [2:0] {
    LDAC_HIT_NONE,
    LDAC_HIT_INDIV,
    LDAC_HIT_GROUP,
    LDAC_HIT_SUB1,
    LDAC_HIT_SUB2,
    LDAC_HIT_SUB3,
    LDAC_HIT_SOFT_RESET
  } ldac_hit_t;
endpackage : ldac_pkg

// file: rtl/ldac_line_if.sv
// raw and filtered bus lines between filter and decoder
interface ldac_line_if;
  logic scl_raw;
  logic sda_raw;
  logic scl_flt;
  logic sda_flt;
  modport filt (input scl_raw, input sda_raw, output scl_flt, output sda_flt);
  modport dec  (output scl_raw, output sda_raw, input scl_flt, input sda_flt);
endinterface : ldac_line_if

// file: rtl/ldac_spike_filter.sv
// spike filter for scl and sda: a level must hold FILT_CYC samples to pass
`include "ldac_params.svh"
module ldac_spike_filter #(
  parameter int FILT_CYC = `LDAC_SPIKE_CYC
) (
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  ldac_line_if.filt   lines
);
  localparam int CW = (FILT_CYC > 1) ? $clog2(FILT_CYC) : 1;

  generate
    if (FILT_CYC < 1) begin : g_bad
      $error("FILT_CYC must be at least 1");
    end
  endgenerate

  logic [1:0] in_w;
  logic [1:0] out_reg;
  assign in_w          = {lines.scl_raw, lines.sda_raw};
  assign lines.scl_flt = out_reg[1];
  assign lines.sda_flt = out_reg[0];

  // one counter per line; a mismatch shorter than FILT_CYC is dropped
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      logic [CW-1:0] cnt_reg;
      logic [CW-1:0] cnt_next;
      logic          take;
      assign take     = (in_w[i] != out_reg[i]) && (cnt_reg == CW'(FILT_CYC - 1));
      assign cnt_next = (in_w[i] == out_reg[i] || take) ? '0 : cnt_reg + CW'(1);
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          cnt_reg    <= '0;
          out_reg[i] <= 1'b1; // idle bus is high
        end else begin
          cnt_reg <= cnt_next;
          if (take) out_reg[i] <= in_w[i];
        end
      end

      a_spike_dropped : assert property (@(posedge ref_clk) disable iff (!resetn)
        (resetn && $past(resetn, 2) && (out_reg[i] != $past(out_reg[i])))
          |-> ($past(in_w[i]) == out_reg[i]) && ($past(in_w[i], 2) == out_reg[i]))
        else $error("filtered line changed after a short pulse");
    end
  endgenerate
endmodule : ldac_spike_filter

// file: rtl/ldac_addr_decode.sv
// i2c target address front end: filter, time-out, address match and ack
// Overview of operation
// - Either bus line held low for 25 ms resets the serial interface, unless the time-out is off.
// - Pulses shorter than 50 ns on scl or sda are ignored as noise.
// - The last address bit picks the direction: 1 is a read, 0 is a write.
// - The group-call address is 1001 000 after reset and writable, but not kept over power loss.
// - Group-call is on after reset, so bytes 90h and 91h are acknowledged.
// - Three sub-call addresses start as 1001 001, 1001 010 and 1001 100.
// - Sub-call is off after reset, so 92h to 99h get no acknowledge until it is enabled.
// - Sub-call addresses are writable and return to their defaults on reset.
// - The soft reset call is acknowledged only with the write direction.
`include "ldac_params.svh"
module ldac_addr_decode #(
  parameter int TIMEOUT_CYC = `LDAC_TIMEOUT_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [3:0]        hw_addr_strap,
  input  wire logic              timeout_en,
  input  wire logic              group_call_en,
  input  wire logic [2:0]        sub_call_en,
  input  wire logic              group_call_wr,
  input  wire logic [2:0]        sub_call_wr,
  input  wire logic [6:0]        call_wr_data,
  output logic                   addr_match,
  output ldac_pkg::ldac_hit_t    match_kind,
  output logic                   rw_dir,
  output logic                   soft_reset_call,
  output logic                   bus_timeout
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  generate
    if (TIMEOUT_CYC < 2) begin : g_bad
      $error("TIMEOUT_CYC must be at least 2");
    end
  endgenerate

  // filtered lines
  ldac_line_if lines ();
  assign lines.scl_raw = scl_in;
  assign lines.sda_raw = sda_in;
  ldac_spike_filter u_filter (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .lines   (lines)
  );

  // address matching on enable and exact seven bits
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_a, input logic en);
    hit = en && (a == ref_a);
  endfunction : hit

  ldac_pkg::ldac_state_t st_reg;
  ldac_pkg::ldac_state_t st_next;
  logic                  scl_q_reg;
  logic                  sda_q_reg;
  logic [2:0]            bit_cnt_reg;
  logic [6:0]            shift_reg;
  logic [TW-1:0]         lo_cnt_reg;
  logic [3:0]            strap_reg;
  logic [6:0]            group_call_address_reg;
  logic [6:0]            sub_call_address_reg_1;
  logic [6:0]            sub_call_address_reg_2;
  logic [6:0]            sub_call_address_reg_3;
  logic                  sda_oe_reg;
  logic                  sda_out_reg;
  logic                  addr_match_reg;
  ldac_pkg::ldac_hit_t   match_kind_reg;
  logic                  rw_dir_reg;
  logic                  soft_reset_call_reg;
  logic                  bus_timeout_reg;

  // bus events from the filtered lines
  wire scl_f    = lines.scl_flt;
  wire sda_f    = lines.sda_flt;
  wire scl_rise = scl_f && !scl_q_reg;
  wire scl_fall = !scl_f && scl_q_reg;
  wire start_c  = scl_f && scl_q_reg && !sda_f && sda_q_reg;
  wire stop_c   = scl_f && scl_q_reg && sda_f && !sda_q_reg;
  wire line_low = !scl_f || !sda_f;
  wire tmo_hit  = timeout_en && line_low && (lo_cnt_reg == TW'(TIMEOUT_CYC - 1));
  wire addr_done = (st_reg == ldac_pkg::LDAC_ADDR) && scl_rise && (bit_cnt_reg == `LDAC_LAST_BIT);
  wire [6:0] addr7 = shift_reg;
  wire       dir_bit = sda_f;

  // address decode, priority own, soft reset, group, subs
  wire [6:0] own_addr = {`LDAC_FIXED_UPPER, strap_reg};
  wire h_indiv = hit(addr7, own_addr, 1'b1);
  wire h_soft_reset_call = hit(addr7, `LDAC_SOFT_RESET_ADDR, dir_bit != `LDAC_DIR_READ);
  wire h_group = hit(addr7, group_call_address_reg, group_call_en);
  wire h_sub1  = hit(addr7, sub_call_address_reg_1, sub_call_en[0]);
  wire h_sub2  = hit(addr7, sub_call_address_reg_2, sub_call_en[1]);
  wire h_sub3  = hit(addr7, sub_call_address_reg_3, sub_call_en[2]);
  wire any_hit = h_indiv || h_soft_reset_call || h_group || h_sub1 || h_sub2 || h_sub3;
  ldac_pkg::ldac_hit_t kind_w;
  assign kind_w = h_indiv ? ldac_pkg::LDAC_HIT_INDIV :
                  h_soft_reset_call ? ldac_pkg::LDAC_HIT_SOFT_RESET :
                  h_group ? ldac_pkg::LDAC_HIT_GROUP :
                  h_sub1  ? ldac_pkg::LDAC_HIT_SUB1 :
                  h_sub2  ? ldac_pkg::LDAC_HIT_SUB2 :
                  h_sub3  ? ldac_pkg::LDAC_HIT_SUB3 : ldac_pkg::LDAC_HIT_NONE;

  // state sequencing: start always restarts address capture
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ldac_pkg::LDAC_IDLE:     st_next = st_reg;
      ldac_pkg::LDAC_ADDR:     if (addr_done) st_next = any_hit ? ldac_pkg::LDAC_ACK_WAIT
                                                               : ldac_pkg::LDAC_PASS;
      ldac_pkg::LDAC_ACK_WAIT: if (scl_fall) st_next = ldac_pkg::LDAC_ACK;
      ldac_pkg::LDAC_ACK:      if (scl_fall) st_next = ldac_pkg::LDAC_PASS;
      ldac_pkg::LDAC_PASS:     st_next = st_reg;
      default:                 st_next = ldac_pkg::LDAC_IDLE;
    endcase
    if (start_c) st_next = ldac_pkg::LDAC_ADDR;
    if (stop_c || tmo_hit) st_next = ldac_pkg::LDAC_IDLE;
  end

  wire          sda_oe_next = (st_next == ldac_pkg::LDAC_ACK);
  // counter parks one past the firing point, so a long low gives a single pulse
  wire          lo_full     = (lo_cnt_reg == TW'(TIMEOUT_CYC));
  wire [TW-1:0] lo_next     = (!timeout_en || !line_low) ? '0 :
                              lo_full ? lo_cnt_reg : lo_cnt_reg + TW'(1);

  // bus front end registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg      <= ldac_pkg::LDAC_IDLE;
      scl_q_reg   <= 1'b1;
      sda_q_reg   <= 1'b1;
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
      lo_cnt_reg  <= '0;
      strap_reg   <= '0;
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      scl_q_reg   <= scl_f;
      sda_q_reg   <= sda_f;
      lo_cnt_reg  <= lo_next;
      strap_reg   <= hw_addr_strap;
      sda_oe_reg  <= sda_oe_next;
      sda_out_reg <= 1'b0; // ack drives low only
      if (start_c) bit_cnt_reg <= '0;
      else if (st_reg == ldac_pkg::LDAC_ADDR && scl_rise) bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (st_reg == ldac_pkg::LDAC_ADDR && scl_rise && !addr_done)
        shift_reg <= {shift_reg[5:0], sda_f};
    end
  end

  // call address registers, volatile, defaults on reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      group_call_address_reg <= `LDAC_GROUP_DEFAULT;
      sub_call_address_reg_1 <= `LDAC_SUB1_DEFAULT;
      sub_call_address_reg_2 <= `LDAC_SUB2_DEFAULT;
      sub_call_address_reg_3 <= `LDAC_SUB3_DEFAULT;
    end else begin
      if (group_call_wr) group_call_address_reg <= call_wr_data;
      if (sub_call_wr[0]) sub_call_address_reg_1 <= call_wr_data;
      if (sub_call_wr[1]) sub_call_address_reg_2 <= call_wr_data;
      if (sub_call_wr[2]) sub_call_address_reg_3 <= call_wr_data;
    end
  end

  // result flags: one-cycle pulses, kind and direction held
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      addr_match_reg      <= 1'b0;
      match_kind_reg      <= ldac_pkg::LDAC_HIT_NONE;
      rw_dir_reg          <= 1'b0;
      soft_reset_call_reg <= 1'b0;
      bus_timeout_reg     <= 1'b0;
    end else begin
      addr_match_reg      <= addr_done && any_hit;
      soft_reset_call_reg <= addr_done && (kind_w == ldac_pkg::LDAC_HIT_SOFT_RESET);
      bus_timeout_reg     <= tmo_hit;
      if (addr_done) begin
        match_kind_reg <= kind_w;
        rw_dir_reg     <= dir_bit;
      end
    end
  end

  assign sda_out         = sda_out_reg;
  assign sda_oe          = sda_oe_reg;
  assign addr_match      = addr_match_reg;
  assign match_kind      = match_kind_reg;
  assign rw_dir          = rw_dir_reg;
  assign soft_reset_call = soft_reset_call_reg;
  assign bus_timeout     = bus_timeout_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_timeout_fires : assert property (tmo_hit |=> bus_timeout_reg
      && st_reg == ldac_pkg::LDAC_IDLE && !sda_oe_reg)
    else $error("time-out did not reset the interface");
  a_timeout_off : assert property (!timeout_en |=> lo_cnt_reg == '0 && !bus_timeout_reg)
    else $error("time-out counted while disabled");
  a_timeout_once : assert property (bus_timeout_reg |=> !bus_timeout_reg)
    else $error("time-out pulse longer than one cycle");
  a_dir_capture : assert property (addr_done |=> rw_dir_reg == $past(sda_f))
    else $error("direction bit not captured");
  a_call_defaults : assert property ($past(!resetn) |-> group_call_address_reg == `LDAC_GROUP_DEFAULT
      && sub_call_address_reg_1 == `LDAC_SUB1_DEFAULT
      && sub_call_address_reg_2 == `LDAC_SUB2_DEFAULT
      && sub_call_address_reg_3 == `LDAC_SUB3_DEFAULT)
    else $error("call address defaults wrong");
  a_group_ack : assert property (addr_done && group_call_en
      && addr7 == group_call_address_reg |=> st_reg == ldac_pkg::LDAC_ACK_WAIT)
    else $error("group call not acknowledged");
  a_sub_blocked : assert property (addr_done && !h_indiv && !h_soft_reset_call && !h_group
      && (addr7 == sub_call_address_reg_1) && !sub_call_en[0]
      && !h_sub2 && !h_sub3 |=> st_reg == ldac_pkg::LDAC_PASS)
    else $error("disabled sub-call acknowledged");
  a_soft_reset_call_write : assert property (soft_reset_call_reg |-> !rw_dir_reg && addr_match_reg)
    else $error("soft reset call taken on a read");
  a_own_match : assert property (addr_done && addr7 == {`LDAC_FIXED_UPPER, strap_reg}
      |=> addr_match_reg && match_kind_reg == ldac_pkg::LDAC_HIT_INDIV)
    else $error("own address not matched");
  a_ack_window : assert property (st_reg == ldac_pkg::LDAC_ACK_WAIT && scl_fall && !start_c
      && !stop_c && !tmo_hit |=> sda_oe_reg && !sda_out_reg)
    else $error("ack not driven in ninth clock");
  a_miss_release : assert property (addr_done && !any_hit |=> !sda_oe_reg [*2])
    else $error("bus driven after an address miss");
endmodule : ldac_addr_decode

// file: test/ldac_bus_master.sv
// i2c controller model: drives scl, shares open-drain sda with the target
module ldac_bus_master #(
  parameter int H = 8
) (
  input  wire logic ref_clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_drv;
  // pull-up on sda: low while the master pulls it or the target enables a low drive
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // wait n clock edges, then step just off the edge
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : hc
  // hold one line low for n cycles, then release it
  task automatic hold_low(input logic on_scl, input int n);
    scl = ~on_scl;
    sda_drv = on_scl;
    hc(n);
    scl = 1'b1;
    sda_drv = 1'b1;
    hc(H);
  endtask : hold_low
  // start, address byte, ninth clock, stop; g adds 25 ns spikes
  task automatic frame(input logic [7:0] b, input logic g, output logic ack);
    sda_drv = 1'b0; // start comes before the address byte
    hc(H);
    scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i]; // msb first, bit 0 selects direction
      hc(H);
      scl = 1'b1;
      hc(H / 2);
      if (g) begin
        sda_drv = ~b[i]; // one-cycle spike on sda
        hc(1);
        sda_drv = b[i];
        hc(1);
        scl = 1'b0; // one-cycle spike on scl
        hc(1);
        scl = 1'b1;
      end
      hc(g ? H / 2 - 3 : H / 2);
      scl = 1'b0;
    end
    sda_drv = 1'b1; // release sda for the ninth clock
    hc(H);
    scl = 1'b1;
    hc(H / 2);
    ack = ~sda;
    hc(H / 2);
    scl = 1'b0;
    hc(H);
    sda_drv = 1'b0; // stop
    hc(H);
    scl = 1'b1;
    hc(H);
    sda_drv = 1'b1;
    hc(H);
  endtask : frame
endmodule : ldac_bus_master

// file: test/tb_top.sv
// self-checking bench for the i2c address decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 64;
  logic       ref_clk, resetn, scl, sda, sda_oe, sda_out, addr_match, rw_dir;
  logic       soft_reset_call, bus_timeout, timeout_en, group_call_en, group_call_wr, g_on;
  logic [3:0] hw_addr_strap;
  logic [2:0] sub_call_en, sub_call_wr;
  logic [6:0] call_wr_data;
  ldac_pkg::ldac_hit_t match_kind;
  int         err_count, tests_run, n_match, n_soft, n_to, cyc;
  ldac_addr_decode #(.TIMEOUT_CYC(TO)) ldac_addr_decode_inst (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_addr_strap(hw_addr_strap), .timeout_en(timeout_en),
    .group_call_en(group_call_en), .sub_call_en(sub_call_en), .group_call_wr(group_call_wr),
    .sub_call_wr(sub_call_wr), .call_wr_data(call_wr_data), .addr_match(addr_match),
    .match_kind(match_kind), .rw_dir(rw_dir), .soft_reset_call(soft_reset_call),
    .bus_timeout(bus_timeout));
  ldac_bus_master ldac_bus_master_inst (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // pulse counters and run ceiling
  always @(posedge ref_clk) begin
    n_match += (addr_match === 1'b1);
    n_soft += (soft_reset_call === 1'b1);
    n_to += (bus_timeout === 1'b1);
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("unexpected run length: expected under 30000 cycles seen %0d", cyc);
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one address frame, judged on ack, kind, direction, pulses and release
  task automatic xfer(input logic [7:0] b, input ldac_pkg::ldac_hit_t k);
    logic ack;
    int   m0, s0;
    m0 = n_match;
    s0 = n_soft;
    ldac_bus_master_inst.frame(b, g_on, ack);
    chk("ack", {7'h0, k != ldac_pkg::LDAC_HIT_NONE}, {7'h0, ack});
    chk("kind", 8'(k), 8'(match_kind));
    chk("match pulses", {7'h0, k != ldac_pkg::LDAC_HIT_NONE}, 8'(n_match - m0));
    chk("soft reset pulses", {7'h0, k == ldac_pkg::LDAC_HIT_SOFT_RESET}, 8'(n_soft - s0));
    chk("sda drive value", 8'h0, {7'h0, sda_out});
    chk("sda release", 8'h0, {7'h0, sda_oe});
    if (k != ldac_pkg::LDAC_HIT_NONE) chk("direction", {7'h0, b[0]}, {7'h0, rw_dir});
  endtask : xfer
  // power-up call set with straps 5: own 45h; 44h and all sub-calls refused
  task automatic t_calls;
    logic [7:0] bs [13] = '{8'h8a, 8'h8b, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95,
                            8'h98, 8'h99, 8'h06, 8'h07, 8'h88};
    ldac_pkg::ldac_hit_t ks [13] = '{ldac_pkg::LDAC_HIT_INDIV, ldac_pkg::LDAC_HIT_INDIV,
      ldac_pkg::LDAC_HIT_GROUP, ldac_pkg::LDAC_HIT_GROUP, ldac_pkg::LDAC_HIT_NONE,
      ldac_pkg::LDAC_HIT_NONE, ldac_pkg::LDAC_HIT_NONE, ldac_pkg::LDAC_HIT_NONE,
      ldac_pkg::LDAC_HIT_NONE, ldac_pkg::LDAC_HIT_NONE, ldac_pkg::LDAC_HIT_SOFT_RESET,
      ldac_pkg::LDAC_HIT_NONE, ldac_pkg::LDAC_HIT_NONE};
    for (int i = 0; i < 13; i++) xfer(bs[i], ks[i]);
    $display("done power-up calls");
  endtask : t_calls
  // sub-call defaults once enabled, per-bit enables, group disabled
  task automatic t_sub;
    sub_call_en = 3'h7;
    group_call_en = 1'b0;
    xfer(8'h92, ldac_pkg::LDAC_HIT_SUB1);
    xfer(8'h95, ldac_pkg::LDAC_HIT_SUB2);
    xfer(8'h98, ldac_pkg::LDAC_HIT_SUB3);
    xfer(8'h90, ldac_pkg::LDAC_HIT_NONE);
    sub_call_en = 3'h2;
    xfer(8'h92, ldac_pkg::LDAC_HIT_NONE);
    xfer(8'h94, ldac_pkg::LDAC_HIT_SUB2);
    group_call_en = 1'b1;
    $display("done sub-calls");
  endtask : t_sub
  // new call addresses take effect and are lost on reset
  task automatic t_reprog;
    sub_call_en = 3'h1;
    call_wr_data = 7'h20;
    group_call_wr = 1'b1;
    step(1);
    group_call_wr = 1'b0;
    call_wr_data = 7'h21;
    sub_call_wr = 3'h1;
    step(1);
    sub_call_wr = 3'h0;
    xfer(8'h40, ldac_pkg::LDAC_HIT_GROUP);
    xfer(8'h90, ldac_pkg::LDAC_HIT_NONE);
    xfer(8'h43, ldac_pkg::LDAC_HIT_SUB1);
    xfer(8'h92, ldac_pkg::LDAC_HIT_NONE);
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    xfer(8'h91, ldac_pkg::LDAC_HIT_GROUP);
    xfer(8'h92, ldac_pkg::LDAC_HIT_SUB1);
    xfer(8'h42, ldac_pkg::LDAC_HIT_NONE);
    sub_call_en = 3'h0;
    $display("done reprogramming");
  endtask : t_reprog
  // 25 ns spikes on both lines inside every address bit
  task automatic t_spike;
    g_on = 1'b1;
    xfer(8'h8a, ldac_pkg::LDAC_HIT_INDIV);
    xfer(8'h06, ldac_pkg::LDAC_HIT_SOFT_RESET);
    g_on = 1'b0;
    $display("done spikes");
  endtask : t_spike
  // low-line time-out: just short, long on each line, and disabled
  task automatic t_timeout;
    int t0;
    timeout_en = 1'b1;
    t0 = n_to;
    ldac_bus_master_inst.hold_low(1'b1, TO - 8);
    chk("short low time-outs", 8'h0, 8'(n_to - t0));
    ldac_bus_master_inst.hold_low(1'b1, TO + 8);
    chk("scl low time-outs", 8'h1, 8'(n_to - t0));
    ldac_bus_master_inst.hold_low(1'b0, TO + 8);
    chk("sda low time-outs", 8'h2, 8'(n_to - t0));
    timeout_en = 1'b0;
    ldac_bus_master_inst.hold_low(1'b1, 2 * TO);
    chk("disabled time-outs", 8'h2, 8'(n_to - t0));
    xfer(8'h8b, ldac_pkg::LDAC_HIT_INDIV);
    $display("done time-out");
  endtask : t_timeout
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // straps 5 keep the own address off every call default
  initial begin
    {resetn, timeout_en, group_call_wr, g_on} = 4'h0;
    group_call_en = 1'b1;
    {sub_call_en, sub_call_wr} = 6'h0;
    hw_addr_strap = 4'h5;
    call_wr_data = 7'h0;
    {err_count, tests_run, n_match, n_soft, n_to, cyc} = '0;
    step(20);
    resetn = 1'b1;
    t_calls();
    t_sub();
    t_reprog();
    t_spike();
    t_timeout();
    close_out();
  end
endmodule : tb_top
